// ==== test/acs_link_sva.sv ====
// Timing checks on the link between the sequencer and its controller.
`timescale 1ns/1ps
`default_nettype none
module acs_link_sva (
  input wire logic                        clk_i,
  input wire logic                        sys_rst_i,
  input wire logic                        converter_reset,
  input wire logic                        conversion_start,
  input wire logic                        calibration_active,
  input wire logic                        sampling_flag,
  input wire logic                        busy,
  input wire logic                        result_valid,
  input wire logic [acs_pkg::RESULT_W-1:0] conversion_value
);
  logic [12:0] cal_n_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Counts the cycles that calibration really stood since the converter left reset.
  always_ff @(posedge clk_i)
    if (sys_rst_i || converter_reset)
      cal_n_r <= 13'h0;
    else if (calibration_active)
      cal_n_r <= cal_n_r + 13'h1;
  sequence smp_s;
    sampling_flag [*4] ##1 (!sampling_flag && busy);
  endsequence
  sequence cvt_s;
    busy [*8] ##1 busy [*8] ##1 (!busy && result_valid);
  endsequence
  cal_len_a: assert property ($fell(calibration_active) |-> cal_n_r == 13'hf00)
    else $error("calibration length wrong");
  cal_max_a: assert property (cal_n_r <= 13'hf00)
    else $error("calibration runs too long");
  cal_quiet_a: assert property (calibration_active |-> !busy && !sampling_flag)
    else $error("conversion during calibration");
  start_go_a: assert property (conversion_start && !converter_reset && !calibration_active
    && !busy && !$past(busy, 1) && !$past(busy, 2) && !$past(busy, 3)
    |=> sampling_flag && busy && !result_valid)
    else $error("start not answered");
  smp_len_a: assert property ($rose(sampling_flag) |-> smp_s)
    else $error("sampling length wrong");
  busy_len_a: assert property ($rose(busy) |-> cvt_s)
    else $error("conversion length wrong");
  one_start_a: assert property ($rose(sampling_flag) |-> $rose(busy))
    else $error("start taken while busy");
  vld_clr_a: assert property (conversion_start && result_valid && !busy
    && !calibration_active && !converter_reset |=> !result_valid)
    else $error("valid not cleared");
  vld_hold_a: assert property (result_valid && !conversion_start && !converter_reset
    |=> result_valid)
    else $error("valid dropped early");
  val_hold_a: assert property (!$rose(result_valid) && !$past(converter_reset)
    |-> $stable(conversion_value))
    else $error("value changed between results");
  post_gap_a: assert property ($fell(busy) |-> !sampling_flag [*2])
    else $error("no post calibration slot");
endmodule
`default_nettype wire

// ==== test/adc_conversion_sequencer_bench.sv ====
// Bench for both ends: register traffic on the controller, link watched by the checker.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_bench;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq_o, hold_strobe_o;
  logic [3:0] cal_step_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] raw_sample_i = 12'h000;
  logic [7:0] cal_measure_i = 8'h00;
  logic [4:0] hold_channel_o, seen_ch;
  logic [4:0] chs [3] = '{5'h00, 5'h1f, 5'h05};
  logic [11:0] raws [3] = '{12'h000, 12'hfff, 12'ha5a};
  int errors = 0, n_checks = 0, cyc = 0;
  acs_link_if lnk ();
  acs_device u_acs_device (.clk_i, .sys_rst_i, .link(lnk), .raw_sample_i, .cal_measure_i,
    .hold_channel_o, .hold_strobe_o, .cal_step_o);
  acs_host #(.AVG_SAMPLES(4), .AVG_SHIFT(2)) u_acs_host (.clk_i, .sys_rst_i, .link(lnk),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq_o);
  acs_link_sva u_acs_link_sva (.clk_i, .sys_rst_i, .converter_reset(lnk.converter_reset),
    .conversion_start(lnk.conversion_start), .calibration_active(lnk.calibration_active),
    .sampling_flag(lnk.sampling_flag), .busy(lnk.busy), .result_valid(lnk.result_valid),
    .conversion_value(lnk.conversion_value));
  always #2 clk_i = ~clk_i;
  // Calibration alone takes 3840 cycles; the rest fits well inside the ceiling.
  always @(posedge clk_i)
  begin
    cyc++;
    if (hold_strobe_o)
      seen_ch = hold_channel_o;
    if (cyc == 20000)
    begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] re);
    logic aw, w;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w)
    begin
      @(posedge clk_i);
      if (aw && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    do @(posedge clk_i); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, re});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_i); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    do rd(a, d, r); while ((d & m) == 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(acs_pkg::REG_CTRL, d, r);
    chk(d, acs_pkg::CTRL_RESET);
    rd(acs_pkg::REG_STATUS, d, r);
    chk(d, 32'h1);
    rd(8'h1c, d, r);
    chk({d[29:0], r}, {30'h0, acs_pkg::RESP_SLVERR});
    wr(8'h1c, 32'h1, acs_pkg::RESP_SLVERR);
    wr(acs_pkg::REG_IRQ_EN, 32'h7, acs_pkg::RESP_OKAY);
    // Releases the converter and asks for a start before the channel is configured.
    wr(acs_pkg::REG_CTRL, 32'h1, acs_pkg::RESP_OKAY);
    rd(acs_pkg::REG_IRQ_STAT, d, r);
    chk({d[30:0], irq_o}, 32'h9);
    wr(acs_pkg::REG_IRQ_CLR, 32'h4, acs_pkg::RESP_OKAY);
    rd(acs_pkg::REG_IRQ_STAT, d, r);
    chk({d[30:0], irq_o}, 32'h0);
    do rd(acs_pkg::REG_STATUS, d, r); while (d[0] !== 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      raw_sample_i <= raws[i];
      wr(acs_pkg::REG_CTRL, (32'(chs[i]) << 8) | 32'h9, acs_pkg::RESP_OKAY);
      poll(acs_pkg::REG_IRQ_STAT, 32'h1);
      rd(acs_pkg::REG_RESULT, d, r);
      chk(d, 32'(raws[i]));
      chk(32'(lnk.conversion_value), 32'(raws[i]));
      chk(32'(seen_ch), 32'(chs[i]));
      rd(acs_pkg::REG_STATUS, d, r);
      chk(d & 32'h1f, 32'h8);
      wr(acs_pkg::REG_IRQ_CLR, 32'h1, acs_pkg::RESP_OKAY);
    end
    wr(acs_pkg::REG_CTRL, 32'h030d, acs_pkg::RESP_OKAY);
    poll(acs_pkg::REG_IRQ_STAT, 32'h2);
    rd(acs_pkg::REG_AVERAGE, d, r);
    chk(d, 32'(raws[2]));
    chk(32'(seen_ch), 32'h3);
    // Seven conversions so far, so the post-calibration rotation has moved on seven steps.
    chk(32'(cal_step_o), 32'h7);
    end_sim();
  end
endmodule
`default_nettype wire

// ==== verilog/acs_device.sv ====
// Converter sequencer: calibration, sample/convert sequence and result latch.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module acs_device #(
  parameter int SAMPLE_CYCLES  = acs_pkg::SAMPLE_CYCLES,
  parameter int CONVERT_CYCLES = acs_pkg::CONVERT_CYCLES,
  parameter int POSTCAL_CYCLES = acs_pkg::POSTCAL_CYCLES
) (
  input  wire logic                             clk_i,
  input  wire logic                             sys_rst_i,
  acs_link_if.dev                               link,
  input  wire logic [acs_pkg::RESULT_W-1:0]     raw_sample_i,
  input  wire logic [acs_pkg::CAL_WORD_W-1:0]   cal_measure_i,
  output logic      [acs_pkg::CHAN_W-1:0]       hold_channel_o,
  output logic                                  hold_strobe_o,
  output logic      [acs_pkg::STEP_W-1:0]       cal_step_o
);

  localparam int RW = acs_pkg::RESULT_W;
  localparam int CW = acs_pkg::CAL_WORD_W;
  localparam int NW = acs_pkg::CNT_W;

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  acs_pkg::acs_dev_state_t           state_r;
  acs_pkg::acs_dev_state_t           state_nxt;
  logic [NW-1:0]                     cnt_r;
  logic [acs_pkg::CHAN_W-1:0]        chan_r;
  logic                              pending_r;
  logic                              valid_r;
  logic [RW-1:0]                     value_r;
  logic [RW-1:0]                     raw_r;
  logic [CW-1:0]                     offset_r;
  logic [CW-1:0]                     trim_r [RW];
  logic [acs_pkg::STEP_W-1:0]        step_r;
  logic [acs_pkg::STEP_W-1:0]        cal_step_r;
  logic [acs_pkg::CHAN_W-1:0]        hold_chan_r;
  logic                              hold_stb_r;
  logic [RW-1:0]                     corrected;

  wire rst_all     = sys_rst_i | link.converter_reset;
  wire in_cal      = (state_r == acs_pkg::DS_CAL);
  wire in_idle     = (state_r == acs_pkg::DS_IDLE);
  wire in_sample   = (state_r == acs_pkg::DS_SAMPLE);
  wire in_convert  = (state_r == acs_pkg::DS_CONVERT);
  wire in_postcal  = (state_r == acs_pkg::DS_POSTCAL);
  // Starts during calibration or a running conversion are dropped.
  wire start_ok    = link.conversion_start & (in_idle | in_postcal);
  wire cal_done    = in_cal & (cnt_r == acs_pkg::CAL_CYCLES - 12'd1);
  wire sample_done = in_sample & (cnt_r == NW'(SAMPLE_CYCLES - 1));
  wire conv_done   = in_convert & (cnt_r == NW'(CONVERT_CYCLES - 1));
  wire post_done   = in_postcal & (cnt_r == NW'(POSTCAL_CYCLES - 1));
  // During calibration each of the first 13 256-cycle slots (0 to 12) trims one element of the array.
  wire cal_slot_end = in_cal & (cnt_r[7:0] == 8'hff);
  wire [acs_pkg::STEP_W-1:0] cal_slot = cnt_r[11:8];

  // ----------------------------------------------------------------
  // Correction: subtract offset, add trims of set result bits
  // ----------------------------------------------------------------
  always_comb
  begin
    logic signed [15:0] acc;
    acc = $signed({4'h0, raw_r}) - $signed({8'h00, offset_r});
    for (int b = 0; b < RW; b++)
    begin
      if (raw_r[b])
      begin
        acc = acc + 16'($signed(trim_r[b]));
      end
    end
    if (acc < 16'sd0)
    begin
      corrected = '0;
    end
    else if (acc > 16'sd4095)
    begin
      corrected = '1;
    end
    else
    begin
      corrected = acc[RW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      acs_pkg::DS_CAL:     if (cal_done) state_nxt = acs_pkg::DS_IDLE;
      acs_pkg::DS_IDLE:    if (start_ok) state_nxt = acs_pkg::DS_SAMPLE;
      acs_pkg::DS_SAMPLE:  if (sample_done) state_nxt = acs_pkg::DS_CONVERT;
      acs_pkg::DS_CONVERT: if (conv_done) state_nxt = acs_pkg::DS_POSTCAL;
      acs_pkg::DS_POSTCAL:
        if (post_done)
        begin
          state_nxt = (pending_r | start_ok) ? acs_pkg::DS_SAMPLE : acs_pkg::DS_IDLE;
        end
      default:             state_nxt = acs_pkg::DS_CAL;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      state_r <= acs_pkg::DS_CAL;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? '0 : cnt_r + 12'd1;
    end
  end

  // A start that lands during post-calibration waits for it to finish.
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      pending_r <= 1'b0;
      chan_r    <= '0;
    end
    else
    begin
      if (start_ok)
      begin
        chan_r <= link.channel_select;
      end
      if (in_postcal & start_ok & ~post_done)
      begin
        pending_r <= 1'b1;
      end
      else if (post_done)
      begin
        pending_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result and valid flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      valid_r <= 1'b0;
      value_r <= '0;
    end
    else if (conv_done)
    begin
      valid_r <= 1'b1;
      value_r <= corrected;
    end
    else if (start_ok)
    begin
      valid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Hold strobe to the front end and capture of the raw code
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      raw_r       <= '0;
      hold_stb_r  <= 1'b0;
      hold_chan_r <= '0;
    end
    else
    begin
      hold_stb_r <= sample_done;
      if (state_nxt == acs_pkg::DS_SAMPLE && !in_sample)
      begin
        hold_chan_r <= start_ok ? link.channel_select : chan_r;
      end
      if (sample_done)
      begin
        raw_r <= raw_sample_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration array
  // ----------------------------------------------------------------
  // Step 0 is the offset, steps 1 to 12 are the bit weights. The trims
  // survive a converter reset on purpose; power-up calibration rewrites them.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      offset_r <= '0;
      step_r   <= '0;
      for (int i = 0; i < RW; i++)
      begin
        trim_r[i] <= '0;
      end
    end
    else if (cal_slot_end && cal_slot <= acs_pkg::LAST_STEP)
    begin
      if (cal_slot == 4'h0)
      begin
        offset_r <= cal_measure_i;
      end
      else
      begin
        trim_r[cal_slot - 4'h1] <= cal_measure_i;
      end
    end
    else if (post_done)
    begin
      if (step_r == 4'h0)
      begin
        offset_r <= cal_measure_i;
      end
      else
      begin
        trim_r[step_r - 4'h1] <= cal_measure_i;
      end
      step_r <= (step_r == acs_pkg::LAST_STEP) ? 4'h0 : step_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      cal_step_r <= '0;
    end
    else
    begin
      cal_step_r <= in_cal ? cal_slot : step_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all taken from flip-flops
  // ----------------------------------------------------------------
  assign link.calibration_active = state_r[0];
  assign link.sampling_flag      = state_r[2];
  assign link.busy               = state_r[2] | state_r[3];
  assign link.result_valid       = valid_r;
  assign link.conversion_value   = value_r;
  assign hold_channel_o          = hold_chan_r;
  assign hold_strobe_o           = hold_stb_r;
  assign cal_step_o              = cal_step_r;

endmodule

`default_nettype wire

// ==== verilog/acs_host.sv ====
// Fabric controller: AXI4-Lite registers, start issue, capture and averaging.
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module acs_host #(
  parameter int AVG_SAMPLES = acs_pkg::AVG_SAMPLES,
  parameter int AVG_SHIFT   = acs_pkg::AVG_SHIFT
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  acs_link_if.host          link,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output logic              irq_o
);

  localparam int RW = acs_pkg::RESULT_W;
  localparam int IW = acs_pkg::IRQ_W;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic [7:0]  awaddr_r;
  logic        aw_have_r;
  logic [31:0] wdata_r;
  logic        w_have_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire aw_take  = s_axi_awvalid & ~aw_have_r & ~bvalid_r;
  wire w_take   = s_axi_wvalid & ~w_have_r & ~bvalid_r;
  wire wr_fire  = aw_have_r & w_have_r & ~bvalid_r;
  wire wr_ctrl  = wr_fire & (awaddr_r == acs_pkg::REG_CTRL);
  wire wr_en    = wr_fire & (awaddr_r == acs_pkg::REG_IRQ_EN);
  wire wr_clr   = wr_fire & (awaddr_r == acs_pkg::REG_IRQ_CLR);
  wire wr_ok    = wr_ctrl | wr_en | wr_clr;
  wire ar_take  = s_axi_arvalid & ~rvalid_r;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= acs_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (wr_fire)
      begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
      end
      else if (bvalid_r & s_axi_bready)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers and link sequencing
  // ----------------------------------------------------------------
  acs_pkg::acs_host_state_t hs_r;
  logic [31:0]       ctrl_r;
  logic              start_req_r;
  logic              start_r;
  logic [RW-1:0]     result_r;
  logic [RW-1:0]     avg_r;
  logic [acs_pkg::SUM_W-1:0] sum_r;
  logic [AVG_SHIFT:0] avg_cnt_r;
  logic              valid_d_r;
  logic [IW-1:0]     irq_stat_r;
  logic [IW-1:0]     irq_en_r;
  logic              irq_r;
  logic [IW-1:0]     irq_evt;

  // Software may write start only when the channel is marked configured.
  wire start_wr  = wr_ctrl & wdata_r[acs_pkg::CTRL_START] & wdata_r[acs_pkg::CTRL_CHCFG];
  wire refused   = wr_ctrl & wdata_r[acs_pkg::CTRL_START] & ~wdata_r[acs_pkg::CTRL_CHCFG];
  wire can_start = ~link.calibration_active & ~link.busy & ~ctrl_r[acs_pkg::CTRL_CRST];
  wire issue     = (hs_r == acs_pkg::HS_IDLE) & start_req_r & can_start;
  wire done_evt  = link.result_valid & ~valid_d_r & (hs_r == acs_pkg::HS_WEND);
  wire avg_mode  = ctrl_r[acs_pkg::CTRL_AVG];
  wire avg_last  = done_evt & avg_mode & (avg_cnt_r == (AVG_SHIFT+1)'(AVG_SAMPLES - 1));
  wire [acs_pkg::SUM_W-1:0] sum_add = sum_r + acs_pkg::SUM_W'(link.conversion_value);

  assign irq_evt = {refused, avg_last, done_evt};

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_r      <= acs_pkg::CTRL_RESET;
      start_req_r <= 1'b0;
      start_r     <= 1'b0;
      hs_r        <= acs_pkg::HS_IDLE;
      valid_d_r   <= 1'b0;
    end
    else
    begin
      valid_d_r <= link.result_valid;
      start_r   <= issue;
      if (wr_ctrl)
      begin
        ctrl_r <= wdata_r & 32'h0000_1f0e;
      end
      if (start_wr)
      begin
        start_req_r <= 1'b1;
      end
      else if (issue)
      begin
        start_req_r <= 1'b0;
      end
      unique case (hs_r)
        acs_pkg::HS_IDLE: if (issue) hs_r <= acs_pkg::HS_WBSY;
        acs_pkg::HS_WBSY: if (link.busy) hs_r <= acs_pkg::HS_WEND;
        acs_pkg::HS_WEND:
          if (done_evt)
          begin
            hs_r <= acs_pkg::HS_IDLE;
            // Averaging keeps the converter running without software help.
            if (avg_mode & ~avg_last)
            begin
              start_req_r <= 1'b1;
            end
          end
        default:          hs_r <= acs_pkg::HS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Capture, averaging and interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      result_r   <= '0;
      avg_r      <= '0;
      sum_r      <= '0;
      avg_cnt_r  <= '0;
      irq_stat_r <= '0;
      irq_en_r   <= '0;
      irq_r      <= 1'b0;
    end
    else
    begin
      if (done_evt)
      begin
        result_r <= link.conversion_value;
        if (avg_mode)
        begin
          sum_r     <= avg_last ? '0 : sum_add;
          avg_cnt_r <= avg_last ? '0 : avg_cnt_r + 1'b1;
        end
      end
      if (avg_last)
      begin
        avg_r <= RW'(sum_add >> AVG_SHIFT);
      end
      if (wr_en)
      begin
        irq_en_r <= wdata_r[IW-1:0];
      end
      // A new event beats a clear written in the same cycle.
      irq_stat_r <= (irq_stat_r & ~(wr_clr ? wdata_r[IW-1:0] : '0)) | irq_evt;
      irq_r      <= |(irq_stat_r & irq_en_r);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  wire [31:0] status_w = {27'h0, hs_r != acs_pkg::HS_IDLE, link.result_valid,
                          link.busy, link.sampling_flag, link.calibration_active};
  logic [31:0] rd_mux;
  logic        rd_ok;

  always_comb
  begin
    rd_ok  = 1'b1;
    rd_mux = '0;
    unique case (s_axi_araddr)
      acs_pkg::REG_CTRL:     rd_mux = ctrl_r | {31'h0, start_req_r};
      acs_pkg::REG_STATUS:   rd_mux = status_w;
      acs_pkg::REG_RESULT:   rd_mux = {20'h0, result_r};
      acs_pkg::REG_AVERAGE:  rd_mux = {20'h0, avg_r};
      acs_pkg::REG_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
      acs_pkg::REG_IRQ_EN:   rd_mux = {29'h0, irq_en_r};
      acs_pkg::REG_IRQ_CLR:  rd_mux = '0;
      default:               rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= acs_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_ok ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
    end
    else if (rvalid_r & s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready         = ~aw_have_r & ~bvalid_r;
  assign s_axi_wready          = ~w_have_r & ~bvalid_r;
  assign s_axi_bvalid          = bvalid_r;
  assign s_axi_bresp           = bresp_r;
  assign s_axi_arready         = ~rvalid_r;
  assign s_axi_rvalid          = rvalid_r;
  assign s_axi_rdata           = rdata_r;
  assign s_axi_rresp           = rresp_r;
  assign irq_o                 = irq_r;
  assign link.conversion_start = start_r;
  assign link.converter_reset  = ctrl_r[acs_pkg::CTRL_CRST];
  assign link.channel_select   = ctrl_r[acs_pkg::CTRL_CH_LO +: acs_pkg::CHAN_W];

endmodule

`default_nettype wire

// ==== verilog/acs_host_unused.sv ====
// Spare source slot for the controller; it holds no logic.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verilog/acs_link_if.sv ====
// Link between the converter sequencer and the fabric controller.
`timescale 1ns/1ps
`default_nettype none

interface acs_link_if;
  logic                          converter_reset;
  logic                          conversion_start;
  logic [acs_pkg::CHAN_W-1:0]    channel_select;
  logic                          calibration_active;
  logic                          sampling_flag;
  logic                          busy;
  logic                          result_valid;
  logic [acs_pkg::RESULT_W-1:0]  conversion_value;

  modport dev (
    input  converter_reset, conversion_start, channel_select,
    output calibration_active, sampling_flag, busy, result_valid, conversion_value
  );

  modport host (
    output converter_reset, conversion_start, channel_select,
    input  calibration_active, sampling_flag, busy, result_valid, conversion_value
  );
endinterface

`default_nettype wire

// ==== verilog/acs_pkg.sv ====
// Shared constants and types for the converter sequencer and its controller.
package acs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int RESULT_W   = 12;
  localparam int CHAN_W     = 5;
  localparam int CAL_WORD_W = 8;
  localparam int CNT_W      = 12;
  localparam int STEP_W     = 4;
  localparam int SUM_W      = 22;

  // ----------------------------------------------------------------
  // Timing counts in converter clock cycles, last calibration step and averaging setup
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CAL_CYCLES     = 12'd3840;
  localparam int               SAMPLE_CYCLES  = 4;
  localparam int               CONVERT_CYCLES = 12;
  localparam int               POSTCAL_CYCLES = 2;
  localparam logic [STEP_W-1:0] LAST_STEP     = 4'hc;
  localparam int               AVG_SAMPLES    = 1024;
  localparam int               AVG_SHIFT      = 10;

  // ----------------------------------------------------------------
  // Register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_RESULT   = 8'h08;
  localparam logic [7:0] REG_AVERAGE  = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_EN   = 8'h14;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h18;

  // CTRL fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_CRST  = 1;
  localparam int CTRL_AVG   = 2;
  localparam int CTRL_CHCFG = 3;
  localparam int CTRL_CH_LO = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

  // STATUS fields.
  localparam int ST_CAL    = 0;
  localparam int ST_SAMPLE = 1;
  localparam int ST_BUSY   = 2;
  localparam int ST_VALID  = 3;
  localparam int ST_RUN    = 4;

  // Interrupt bits.
  localparam int IRQ_W       = 3;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_AVG     = 1;
  localparam int IRQ_REFUSED = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DS_CAL     = 5'b00001,
    DS_IDLE    = 5'b00010,
    DS_SAMPLE  = 5'b00100,
    DS_CONVERT = 5'b01000,
    DS_POSTCAL = 5'b10000
  } acs_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_WBSY = 3'b010,
    HS_WEND = 3'b100
  } acs_host_state_t;

endpackage
